// ---- logic/dotg_top.sv ----
// Operation
// RULE_01: Observer runs only when function bit 1 is set.
// RULE_02: Bit 2 set limits the observer to first gain set.
// RULE_03: Estimate scaled by signed percent gain, -100 to 100.
// RULE_04: Estimate low-pass filtered, constant 10 to 2500 of 0.01 ms.
// RULE_05: Phase advance 0 to 60 degrees offsets filter lag.
// RULE_06: Software should pick about 45 to 50 degrees of advance.
// RULE_07: Software sets filter constant 100000/(2 pi f) with advance.
// RULE_08: Third gain held 0 to 10000 units of 0.1 ms before stop.
// RULE_09: Third gain is first gain times ratio 50 to 1000 over 100.
// RULE_10: Third gain only in position control mode.
// RULE_11: Software disables third gain with time 0 and ratio 100.
// RULE_12: Third gain scales position and velocity loop gains only.
// RULE_13: Integration, detection and force filters keep first values.
// RULE_14: Second gain condition overrides the third gain period.
// RULE_15: Second to third transition ramps over the switching time.
// RULE_16: Second to first by parameter change still inserts third.
// RULE_17: Third gain raises loop gain just before the motor stops.
// RULE_18: Software tunes from large filter constant and low gain.
// RULE_19: Observer runs only in position or velocity mode, servo on.
// RULE_20: Observer off while the velocity observer bit 0 is set.
// RULE_21: Third gain timer starts at command end, then first gain.
// RULE_22: First gain at reset and servo off, pending period cleared.
`timescale 1ns/1ps
`default_nettype none
module dotg_top
	import dotg_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire dotg_srv_t srv,
	output dotg_out_t ctl_out_reg
);

	dotg_cfg_t cfg_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic wr_fire;
	logic wr_hit;
	logic rd_hit;
	logic [31:0] rd_mux;
	logic [31:0] wr_val;
	logic [31:0] old_val;

	// Byte lane merge for partial writes
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
		begin
			if (strb[b])
				r[8*b +: 8] = data[8*b +: 8];
		end
		return r;
	endfunction

	// Write address channel, held until the write completes
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			aw_addr_reg <= '0;
		end
		else if (ce)
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				s_axi_awready <= 1'b0;
				aw_addr_reg <= s_axi_awaddr;
			end
			else if (wr_fire)
				s_axi_awready <= 1'b1;
		end
	end

	// Write data channel, taken independently of the address
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_wready <= 1'b1;
			w_data_reg <= '0;
			w_strb_reg <= '0;
		end
		else if (ce)
		begin
			if (s_axi_wvalid && s_axi_wready)
			begin
				s_axi_wready <= 1'b0;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			else if (wr_fire)
				s_axi_wready <= 1'b1;
		end
	end

	// A write commits once both halves are in and no response is pending
	assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

	// Write address decode onto the current register contents
	always_comb
	begin
		wr_hit = 1'b1;
		if (aw_addr_reg == OFS_FUNC)
			old_val = {24'h00_0000, cfg_reg.func};
		else if (aw_addr_reg == OFS_GAIN)
			old_val = {16'h0000, cfg_reg.gain};
		else if (aw_addr_reg == OFS_FILT)
			old_val = {16'h0000, cfg_reg.filt};
		else if (aw_addr_reg == OFS_PHASE)
			old_val = {16'h0000, cfg_reg.phase};
		else if (aw_addr_reg == OFS_HOLD)
			old_val = {16'h0000, cfg_reg.hold};
		else if (aw_addr_reg == OFS_RATIO)
			old_val = {16'h0000, cfg_reg.ratio};
		else if (aw_addr_reg == OFS_RAMP)
			old_val = {16'h0000, cfg_reg.ramp};
		else
		begin
			old_val = 32'h0000_0000;
			wr_hit = 1'b0;
		end
		wr_val = merge(old_val, w_data_reg, w_strb_reg);
	end

	// Configuration registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cfg_reg.func <= RST_FUNC;
			cfg_reg.gain <= RST_GAIN;
			cfg_reg.filt <= RST_FILT;
			cfg_reg.phase <= RST_PHASE;
			cfg_reg.hold <= RST_HOLD;
			cfg_reg.ratio <= RST_RATIO;
			cfg_reg.ramp <= RST_RAMP;
		end
		else if (ce && wr_fire)
		begin
			if (aw_addr_reg == OFS_FUNC)
				cfg_reg.func <= wr_val[7:0];
			else if (aw_addr_reg == OFS_GAIN)
				cfg_reg.gain <= wr_val[15:0];
			else if (aw_addr_reg == OFS_FILT)
				cfg_reg.filt <= wr_val[15:0];
			else if (aw_addr_reg == OFS_PHASE)
				cfg_reg.phase <= wr_val[15:0];
			else if (aw_addr_reg == OFS_HOLD)
				cfg_reg.hold <= wr_val[15:0];
			else if (aw_addr_reg == OFS_RATIO)
				cfg_reg.ratio <= wr_val[15:0];
			else if (aw_addr_reg == OFS_RAMP)
				cfg_reg.ramp <= wr_val[15:0];
		end
	end

	// Write response; unmapped addresses answer SLVERR
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end
		else if (ce)
		begin
			if (wr_fire)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? 2'h0 : 2'h2;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Read decode
	always_comb
	begin
		rd_hit = 1'b1;
		if (s_axi_araddr == OFS_FUNC)
			rd_mux = {24'h00_0000, cfg_reg.func};
		else if (s_axi_araddr == OFS_GAIN)
			rd_mux = {16'h0000, cfg_reg.gain};
		else if (s_axi_araddr == OFS_FILT)
			rd_mux = {16'h0000, cfg_reg.filt};
		else if (s_axi_araddr == OFS_PHASE)
			rd_mux = {16'h0000, cfg_reg.phase};
		else if (s_axi_araddr == OFS_HOLD)
			rd_mux = {16'h0000, cfg_reg.hold};
		else if (s_axi_araddr == OFS_RATIO)
			rd_mux = {16'h0000, cfg_reg.ratio};
		else if (s_axi_araddr == OFS_RAMP)
			rd_mux = {16'h0000, cfg_reg.ramp};
		else if (s_axi_araddr == OFS_STATUS)
			rd_mux = {24'h00_0000, ctl_out_reg.gain_set,
				2'h0, ctl_out_reg.aux_second, ctl_out_reg.obs_active};
		else if (s_axi_araddr == OFS_COMP)
			rd_mux = {16'h0000, ctl_out_reg.comp_force};
		else
		begin
			rd_mux = 32'h0000_0000;
			rd_hit = 1'b0;
		end
	end

	// Read channel, one outstanding read
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= 2'h0;
		end
		else if (ce)
		begin
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
			end
			else if (s_axi_rvalid && s_axi_rready)
			begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// Values clamped to their legal ranges before use
	logic [15:0] filt_eff;
	logic [15:0] phase_eff;
	logic [15:0] hold_eff;
	logic [15:0] ratio_eff;
	logic signed [7:0] gain_eff;
	always_comb
	begin
		filt_eff = cfg_reg.filt < FILT_MIN ? FILT_MIN :
			(cfg_reg.filt > FILT_MAX ? FILT_MAX : cfg_reg.filt); // RULE_04
		phase_eff = cfg_reg.phase > PHASE_MAX ? PHASE_MAX : cfg_reg.phase;
		hold_eff = cfg_reg.hold > HOLD_MAX ? HOLD_MAX : cfg_reg.hold;
		ratio_eff = cfg_reg.ratio < RATIO_MIN ? RATIO_MIN :
			(cfg_reg.ratio > RATIO_MAX ? RATIO_MAX : cfg_reg.ratio);
		if ($signed(cfg_reg.gain) > $signed(GAIN_LIM))
			gain_eff = 8'sh64; // RULE_03
		else if ($signed(cfg_reg.gain) < -$signed(GAIN_LIM))
			gain_eff = -8'sh64;
		else
			gain_eff = $signed(cfg_reg.gain[7:0]);
	end

	// Time base: 0.01 ms filter ticks and 0.1 ms hold ticks
	logic [11:0] pre_reg;
	logic [3:0] tens_reg;
	logic tick10_reg;
	logic tick100_reg;
	dotg_gs_t gs;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pre_reg <= '0;
			tens_reg <= '0;
			tick10_reg <= 1'b0;
			tick100_reg <= 1'b0;
		end
		else if (ce)
		begin
			tick10_reg <= pre_reg == 12'(FILT_TICK_CYC - 1);
			tick100_reg <= 1'b0;
			if (pre_reg == 12'(FILT_TICK_CYC - 1))
			begin
				pre_reg <= '0;
				tens_reg <= tens_reg == 4'(HOLD_TICK_FILT - 1) ?
					4'h0 : tens_reg + 1'b1;
				tick100_reg <= tens_reg == 4'(HOLD_TICK_FILT - 1);
			end
			else
				pre_reg <= pre_reg + 1'b1;
			// Idle restarts the hold count; the free-running prescaler can still cut a period short by up to one 0.01 ms tick
			if (gs == GS_FIRST || gs == GS_SECOND)
				tens_reg <= '0; // RULE_08
		end
	end

	// Gain set scheduler
	logic [15:0] ramp_e;
	logic [15:0] ramp_n;
	dotg_sched u_sched (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.tick(tick100_reg),
		.servo_on(srv.servo_on),
		.pos_mode(srv.mode == MODE_POS), // RULE_10
		.second_cond(srv.second_cond),
		.pos_cmd_active(srv.pos_cmd_active),
		.param_return(srv.param_return),
		.hold_time(hold_eff),
		.ramp_time(cfg_reg.ramp),
		.state(gs),
		.elapsed(ramp_e),
		.ramp_len(ramp_n)
	);

	// Divider lanes: lane 0 filter step, lanes 1 and 2 the loop gains
	logic [DIV_W-1:0] div_num [DIV_LANES];
	logic [DIV_W-1:0] div_den [DIV_LANES];
	logic [DIV_W-1:0] div_quo [DIV_LANES];
	logic div_start [DIV_LANES];
	logic div_busy [DIV_LANES];
	logic div_done [DIV_LANES];
	genvar gi;
	generate
		for (gi = 0; gi < DIV_LANES; gi++)
		begin : g_div
			dotg_div u_div (
				.aclk(aclk),
				.aresetn(aresetn),
				.ce(ce),
				.start(div_start[gi]),
				.num(div_num[gi]),
				.den(div_den[gi]),
				.busy(div_busy[gi]),
				.done(div_done[gi]),
				.quo(div_quo[gi])
			);
		end
	endgenerate

	// First-order filter in Q16.16: y += (x - y) / T each 0.01 ms
	logic signed [31:0] y_acc_reg;
	logic diff_neg_reg;
	logic signed [32:0] diff;
	logic [32:0] diff_mag;
	assign diff = $signed({srv.dist_est[15], srv.dist_est, 16'h0000})
		- $signed({y_acc_reg[31], y_acc_reg});
	assign diff_mag = diff[32] ? 33'(-diff) : diff;
	assign div_start[0] = tick10_reg;
	assign div_num[0] = {15'h0000, diff_mag};
	assign div_den[0] = {32'h0000_0000, filt_eff}; // RULE_04

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			y_acc_reg <= '0;
			diff_neg_reg <= 1'b0;
		end
		else if (ce)
		begin
			if (div_start[0] && !div_busy[0])
				diff_neg_reg <= diff[32];
			if (div_done[0])
				y_acc_reg <= diff_neg_reg ? y_acc_reg - div_quo[0][31:0]
					: y_acc_reg + div_quo[0][31:0]; // RULE_04
		end
	end

	// Gain lanes: (second*100*(R-e) + first*ratio*e) / (100*R)
	logic [15:0] first_g [2];
	logic [15:0] second_g [2];
	logic [15:0] r_eff;
	logic [15:0] e_eff;
	assign first_g[0] = srv.first_pos_gain;
	assign first_g[1] = srv.first_vel_gain;
	assign second_g[0] = srv.second_pos_gain;
	assign second_g[1] = srv.second_vel_gain;
	assign r_eff = (gs == GS_RAMP && ramp_n != '0) ? ramp_n : 16'h0001;
	assign e_eff = gs == GS_RAMP ? (ramp_e > r_eff ? r_eff : ramp_e)
		: r_eff;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_gain
			assign div_start[gi+1] = 1'b1;
			assign div_num[gi+1] = DIV_W'(second_g[gi] * PERCENT
				* (r_eff - e_eff)) + DIV_W'(first_g[gi] * ratio_eff
				* e_eff); // RULE_09 RULE_15
			assign div_den[gi+1] = DIV_W'(PERCENT * r_eff);
		end
	endgenerate

	// Phase advance gain: tan of the lead angle in Q8, 5 degree steps
	logic [8:0] tan_q8;
	logic [3:0] tan_idx;
	assign tan_idx = 4'((phase_eff + 16'h0002) / 16'h0005);
	always_comb
	begin
		case (tan_idx)
		4'h0: tan_q8 = 9'h000;
		4'h1: tan_q8 = 9'h016;
		4'h2: tan_q8 = 9'h02D;
		4'h3: tan_q8 = 9'h045;
		4'h4: tan_q8 = 9'h05D;
		4'h5: tan_q8 = 9'h077;
		4'h6: tan_q8 = 9'h094;
		4'h7: tan_q8 = 9'h0B3;
		4'h8: tan_q8 = 9'h0D7;
		4'h9: tan_q8 = 9'h100;
		4'hA: tan_q8 = 9'h131;
		4'hB: tan_q8 = 9'h16E;
		default: tan_q8 = 9'h1BB;
		endcase
	end

	// Lead then percent gain; divide by 100 as *1311 >> 17
	logic signed [16:0] err;
	logic signed [26:0] lead_term;
	logic signed [17:0] lead;
	logic signed [39:0] comp_full;
	logic signed [15:0] comp_sat;
	logic obs_on;
	assign err = $signed({srv.dist_est[15], srv.dist_est})
		- $signed({y_acc_reg[31], y_acc_reg[31:16]});
	assign lead_term = err * $signed({1'b0, tan_q8}); // RULE_05
	assign lead = $signed({{2{y_acc_reg[31]}}, y_acc_reg[31:16]})
		+ 18'(lead_term >>> 8);
	assign comp_full = 40'(lead * gain_eff * $signed(13'h051F)) >>> 17;
	assign comp_sat = comp_full > 40'sh00_0000_7FFF ? 16'sh7FFF :
		(comp_full < -40'sh00_0000_8000 ? -16'sh8000 : comp_full[15:0]);
	assign obs_on = cfg_reg.func[FX_DOBS_EN_BIT] // RULE_01
		&& !cfg_reg.func[FX_VOBS_BIT] // RULE_20
		&& srv.servo_on && srv.mode != MODE_FORCE // RULE_19
		&& (!cfg_reg.func[FX_DOBS_FIRST_BIT] || gs == GS_FIRST); // RULE_02

	// Registered outputs; gains outside the ramp and third periods pass through
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctl_out_reg <= '0;
			ctl_out_reg.gain_set <= GS_FIRST;
		end
		else if (ce)
		begin
			ctl_out_reg.gain_set <= gs;
			ctl_out_reg.obs_active <= obs_on;
			ctl_out_reg.comp_force <= obs_on ? comp_sat : 16'h0000; // RULE_03
			ctl_out_reg.aux_second <= gs == GS_SECOND; // RULE_13
			if (gs == GS_SECOND)
			begin
				ctl_out_reg.pos_gain <= second_g[0]; // RULE_14
				ctl_out_reg.vel_gain <= second_g[1];
			end
			else if (gs == GS_FIRST)
			begin
				ctl_out_reg.pos_gain <= first_g[0]; // RULE_22
				ctl_out_reg.vel_gain <= first_g[1];
			end
			else
			begin
				if (div_done[1])
					ctl_out_reg.pos_gain <= |div_quo[1][DIV_W-1:16] ?
						16'hFFFF : div_quo[1][15:0]; // RULE_12
				if (div_done[2])
					ctl_out_reg.vel_gain <= |div_quo[2][DIV_W-1:16] ?
						16'hFFFF : div_quo[2][15:0]; // RULE_12
			end
		end
	end

endmodule
`default_nettype wire

// ---- logic/dotg_pkg.sv ----
package dotg_pkg;

	// Clock and time units
	localparam int CLK_PERIOD_NS = 4;
	localparam int FILT_UNIT_NS = 10000; // 0.01 ms
	localparam int FILT_TICK_CYC = (FILT_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_UNIT_NS = 100000; // 0.1 ms
	localparam int HOLD_TICK_FILT = HOLD_UNIT_NS / FILT_UNIT_NS;

	// Register byte offsets
	localparam logic [7:0] OFS_FUNC = 8'h00;
	localparam logic [7:0] OFS_GAIN = 8'h04;
	localparam logic [7:0] OFS_FILT = 8'h08;
	localparam logic [7:0] OFS_PHASE = 8'h0C;
	localparam logic [7:0] OFS_HOLD = 8'h10;
	localparam logic [7:0] OFS_RATIO = 8'h14;
	localparam logic [7:0] OFS_RAMP = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1C;
	localparam logic [7:0] OFS_COMP = 8'h20;

	// Values after reset
	localparam logic [7:0] RST_FUNC = 8'h00;
	localparam logic [15:0] RST_GAIN = 16'h0000;
	localparam logic [15:0] RST_FILT = 16'h09C4;
	localparam logic [15:0] RST_PHASE = 16'h0000;
	localparam logic [15:0] RST_HOLD = 16'h0000;
	localparam logic [15:0] RST_RATIO = 16'h0064;
	localparam logic [15:0] RST_RAMP = 16'h0000;

	// Legal ranges, applied when a value is used
	localparam logic [15:0] FILT_MIN = 16'h000A;
	localparam logic [15:0] FILT_MAX = 16'h09C4;
	localparam logic [15:0] PHASE_MAX = 16'h003C;
	localparam logic [15:0] GAIN_LIM = 16'h0064;
	localparam logic [15:0] HOLD_MAX = 16'h2710;
	localparam logic [15:0] RATIO_MIN = 16'h0032;
	localparam logic [15:0] RATIO_MAX = 16'h03E8;
	localparam logic [6:0] PERCENT = 7'h64;

	// Field positions in the function expansion setting
	localparam int FX_VOBS_BIT = 0;
	localparam int FX_DOBS_EN_BIT = 1;
	localparam int FX_DOBS_FIRST_BIT = 2;

	localparam int DIV_W = 48;
	localparam int DIV_CNT_W = 6;
	localparam int DIV_LANES = 3;

	typedef enum logic [3:0] {
		GS_FIRST = 4'b0001,
		GS_SECOND = 4'b0010,
		GS_RAMP = 4'b0100,
		GS_THIRD = 4'b1000
	} dotg_gs_t;

	typedef enum logic [1:0] {
		MODE_POS = 2'h0,
		MODE_VEL = 2'h1,
		MODE_FORCE = 2'h2
	} dotg_mode_t;

	typedef struct packed {
		logic [7:0] func;
		logic [15:0] gain;
		logic [15:0] filt;
		logic [15:0] phase;
		logic [15:0] hold;
		logic [15:0] ratio;
		logic [15:0] ramp;
	} dotg_cfg_t;

	typedef struct packed {
		logic servo_on;
		dotg_mode_t mode;
		logic second_cond;
		logic pos_cmd_active;
		logic param_return;
		logic [15:0] dist_est;
		logic [15:0] first_pos_gain;
		logic [15:0] first_vel_gain;
		logic [15:0] second_pos_gain;
		logic [15:0] second_vel_gain;
	} dotg_srv_t;

	typedef struct packed {
		logic [15:0] comp_force;
		logic [15:0] pos_gain;
		logic [15:0] vel_gain;
		dotg_gs_t gain_set;
		logic aux_second;
		logic obs_active;
	} dotg_out_t;

endpackage

// ---- logic/dotg_div.sv ----
`timescale 1ns/1ps
`default_nettype none
module dotg_div
	import dotg_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic start,
	input wire logic [DIV_W-1:0] num,
	input wire logic [DIV_W-1:0] den,
	output logic busy,
	output logic done,
	output logic [DIV_W-1:0] quo
);

	logic [DIV_W-1:0] rem_reg;
	logic [DIV_W-1:0] den_reg;
	logic [DIV_CNT_W-1:0] cnt_reg;
	logic [DIV_W:0] trial;

	// One quotient bit per cycle keeps the area small; results are slow
	// compared with the clock but fast next to the servo cycle
	assign trial = {rem_reg, quo[DIV_W-1]} - {1'b0, den_reg};

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			busy <= 1'b0;
			done <= 1'b0;
			quo <= '0;
			rem_reg <= '0;
			den_reg <= '0;
			cnt_reg <= '0;
		end
		else if (ce)
		begin
			done <= 1'b0;
			if (start && !busy)
			begin
				busy <= 1'b1;
				quo <= num;
				rem_reg <= '0;
				den_reg <= den;
				cnt_reg <= DIV_CNT_W'(DIV_W - 1);
			end
			else if (busy)
			begin
				if (!trial[DIV_W])
				begin
					rem_reg <= trial[DIV_W-1:0];
					quo <= {quo[DIV_W-2:0], 1'b1};
				end
				else
				begin
					rem_reg <= {rem_reg[DIV_W-2:0], quo[DIV_W-1]};
					quo <= {quo[DIV_W-2:0], 1'b0};
				end
				if (cnt_reg == '0)
				begin
					busy <= 1'b0;
					done <= 1'b1;
				end
				cnt_reg <= cnt_reg - 1'b1;
			end
		end
	end

endmodule
`default_nettype wire

// ---- logic/dotg_sched.sv ----
`timescale 1ns/1ps
`default_nettype none
module dotg_sched
	import dotg_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic tick,
	input wire logic servo_on,
	input wire logic pos_mode,
	input wire logic second_cond,
	input wire logic pos_cmd_active,
	input wire logic param_return,
	input wire logic [15:0] hold_time,
	input wire logic [15:0] ramp_time,
	output dotg_gs_t state,
	output logic [15:0] elapsed,
	output logic [15:0] ramp_len
);

	logic [15:0] timer_reg;
	logic cmd_prev_reg;
	logic cmd_end;
	logic leave_second;

	assign cmd_end = cmd_prev_reg && !pos_cmd_active;
	assign leave_second = !second_cond || param_return;

	// Gain set sequencing, one step per clock, timed in 0.1 ms ticks
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state <= GS_FIRST; // RULE_22
			timer_reg <= '0;
			elapsed <= '0;
			ramp_len <= '0;
			cmd_prev_reg <= 1'b0;
		end
		else if (ce)
		begin
			cmd_prev_reg <= pos_cmd_active;
			if (!servo_on)
			begin
				state <= GS_FIRST; // RULE_22
				timer_reg <= '0;
				elapsed <= '0;
			end
			else
			begin
				case (state)
				GS_FIRST:
					if (second_cond)
						state <= GS_SECOND;
					else if (pos_mode && cmd_end && hold_time != '0)
					begin
						state <= GS_THIRD; // RULE_21 RULE_17
						timer_reg <= hold_time;
					end
				GS_SECOND:
					if (leave_second)
					begin
						if (pos_mode && hold_time != '0)
						begin
							// Zero switching time steps straight to third
							state <= ramp_time == '0 ? GS_THIRD
								: GS_RAMP; // RULE_15 RULE_16
							timer_reg <= hold_time;
							elapsed <= '0;
							ramp_len <= ramp_time;
						end
						else
							state <= GS_FIRST;
					end
				GS_RAMP, GS_THIRD:
					if (second_cond)
						state <= GS_SECOND; // RULE_14
					else if (!pos_mode || timer_reg == '0)
						state <= GS_FIRST; // RULE_10 RULE_21
					else if (tick)
					begin
						timer_reg <= timer_reg - 1'b1; // RULE_08
						if (state == GS_RAMP)
						begin
							elapsed <= elapsed + 1'b1;
							if (elapsed + 1'b1 >= ramp_len)
								state <= GS_THIRD; // RULE_15
						end
					end
				default:
					state <= GS_FIRST;
				endcase
			end
		end
	end

endmodule
`default_nettype wire

// ---- verification/dotg_top_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module dotg_top_chk
	import dotg_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire dotg_srv_t srv,
	input wire dotg_out_t ctl_out_reg
);
	// One clock domain, so clock and reset are stated once
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Two quiet cycles give the output flops time to clear
	property p_comp_off;
		!ctl_out_reg.obs_active [*2] |-> ctl_out_reg.comp_force == 16'h0000;
	endproperty
	a_comp_off: assert property (p_comp_off)
		else $error("compensation with observer off");
	property p_servo_obs;
		!srv.servo_on [*3] |-> !ctl_out_reg.obs_active;
	endproperty
	a_servo_obs: assert property (p_servo_obs)
		else $error("observer active with servo off");
	property p_force_obs;
		srv.mode == MODE_FORCE [*3] |-> !ctl_out_reg.obs_active;
	endproperty
	a_force_obs: assert property (p_force_obs)
		else $error("observer active in force mode");
	property p_servo_first;
		!srv.servo_on [*3] |-> ctl_out_reg.gain_set == GS_FIRST;
	endproperty
	a_servo_first: assert property (p_servo_first)
		else $error("gain set not first with servo off");
	property p_vel_third;
		srv.mode != MODE_POS [*3] |-> ctl_out_reg.gain_set != GS_THIRD;
	endproperty
	a_vel_third: assert property (p_vel_third)
		else $error("third gain outside position mode");
	property p_third_aux;
		ctl_out_reg.gain_set == GS_THIRD |-> !ctl_out_reg.aux_second;
	endproperty
	a_third_aux: assert property (p_third_aux)
		else $error("second filters used in third period");
	// Second condition must win over a running third period
	property p_second_pri;
		(srv.second_cond && srv.servo_on && srv.mode == MODE_POS) [*4]
			|-> ctl_out_reg.gain_set != GS_THIRD;
	endproperty
	a_second_pri: assert property (p_second_pri)
		else $error("third gain kept under second condition");
	property p_first_gains;
		(ctl_out_reg.gain_set == GS_FIRST && srv.servo_on
			&& $stable(srv.first_pos_gain) && $stable(srv.first_vel_gain)) [*4]
			|-> ctl_out_reg.pos_gain == srv.first_pos_gain
			&& ctl_out_reg.vel_gain == srv.first_vel_gain;
	endproperty
	a_first_gains: assert property (p_first_gains)
		else $error("loop gains differ from first set");
endmodule

bind dotg_top dotg_top_chk chk_u (
	.aclk(aclk),
	.aresetn(aresetn),
	.srv(srv),
	.ctl_out_reg(ctl_out_reg)
);
`default_nettype wire

// ---- verification/dotg_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module dotg_top_tb
	import dotg_pkg::*;
();
	logic aclk, aresetn, ce;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	dotg_srv_t srv;
	dotg_out_t ctl_out_reg;
	int n_errors, checked, cyc, n;
	localparam logic [7:0] OFS_T [7] = '{OFS_FUNC, OFS_GAIN, OFS_FILT,
		OFS_PHASE, OFS_HOLD, OFS_RATIO, OFS_RAMP};
	localparam logic [15:0] RST_T [7] = '{16'(RST_FUNC), RST_GAIN,
		RST_FILT, RST_PHASE, RST_HOLD, RST_RATIO, RST_RAMP};
	// Rows: function bits, mode, servo on, expected observer state
	localparam logic [11:0] OBS_T [7] = '{12'h023, 12'h002, 12'h032,
		12'h02A, 12'h027, 12'h020, 12'h063};

	dotg_top dut_u (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .srv, .ctl_out_reg);

	initial
	begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	task automatic wrap_up();
		if (n_errors == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Each channel is released at the edge that takes it
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] r);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!done)
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
			begin
				done = 1'b1;
				s_axi_bready <= 1'b0;
				chk("bresp", 32'(r), 32'(s_axi_bresp));
			end
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!done)
		begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
			begin
				done = 1'b1;
				s_axi_rready <= 1'b0;
				chk("rdata", d, s_axi_rdata);
				chk("rresp", 32'(r), 32'(s_axi_rresp));
			end
		end
	endtask

	task automatic wait_gs(input dotg_gs_t e, input int lim);
		n = 0;
		while (ctl_out_reg.gain_set !== e && n < lim)
		begin
			@(posedge aclk);
			n++;
		end
		chk("gain_set", 32'(e), 32'(ctl_out_reg.gain_set));
	endtask

	task automatic cmd_end();
		@(posedge aclk);
		srv.pos_cmd_active <= 1'b1;
		repeat (3) @(posedge aclk);
		srv.pos_cmd_active <= 1'b0;
	endtask

	// A hang is cut short well past the one-tick (0.1 ms) hold period the test uses
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			n_errors++;
			wrap_up();
		end
	end

	initial
	begin
		{aresetn, s_axi_awaddr, s_axi_awvalid, s_axi_wdata} = '0;
		{s_axi_wstrb, s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
		{s_axi_arvalid, s_axi_rready} = '0;
		ce = 1'b1;
		srv = '0;
		srv.first_pos_gain = 16'h0064;
		srv.first_vel_gain = 16'h0032;
		srv.second_pos_gain = 16'h012C;
		srv.second_vel_gain = 16'h0096;
		srv.dist_est = 16'h1000;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 7; i++)
			rd(OFS_T[i], 32'(RST_T[i]), 2'h0);
		rd(OFS_STATUS, 32'h0000_0010, 2'h0);
		rd(8'h24, 32'h0000_0000, 2'h2);
		wr(8'h24, 32'h0000_0001, 4'hF, 2'h2);
		wr(OFS_FUNC, 32'hFFFF_FFFF, 4'hF, 2'h0);
		rd(OFS_FUNC, 32'h0000_00FF, 2'h0);
		wr(OFS_FILT, 32'h0000_1234, 4'h1, 2'h0);
		rd(OFS_FILT, 32'h0000_0934, 2'h0);
		// Observer enable against function bits, mode and servo
		for (int i = 0; i < 7; i++)
		begin
			wr(OFS_FUNC, 32'(OBS_T[i][11:4]), 4'hF, 2'h0);
			srv.mode <= dotg_mode_t'(OBS_T[i][3:2]);
			srv.servo_on <= OBS_T[i][1];
			repeat (4) @(posedge aclk);
			chk("obs", 32'(OBS_T[i][0]), 32'(ctl_out_reg.obs_active));
		end
		// Full third period with negative compensation running
		wr(OFS_FUNC, 32'h0000_0002, 4'hF, 2'h0);
		wr(OFS_GAIN, 32'h0000_FF9C, 4'hF, 2'h0);
		wr(OFS_FILT, 32'h0000_000A, 4'hF, 2'h0);
		wr(OFS_PHASE, 32'h0000_002D, 4'hF, 2'h0);
		wr(OFS_HOLD, 32'h0000_0001, 4'hF, 2'h0);
		wr(OFS_RATIO, 32'h0000_00C8, 4'hF, 2'h0);
		cmd_end();
		wait_gs(GS_THIRD, 10);
		repeat (80) @(posedge aclk);
		chk("pos_gain", 32'h0000_00C8, 32'(ctl_out_reg.pos_gain));
		chk("vel_gain", 32'h0000_0064, 32'(ctl_out_reg.vel_gain));
		chk("aux", 32'h0000_0000, 32'(ctl_out_reg.aux_second));
		wait_gs(GS_FIRST, 30000);
		chk("hold", 32'h0000_0001, 32'(n >= 22000 && n <= 25100));
		repeat (4) @(posedge aclk);
		chk("pos_gain", 32'h0000_0064, 32'(ctl_out_reg.pos_gain));
		chk("sign", 32'h0000_0001, 32'(ctl_out_reg.comp_force[15]));
		// Observer limited to first set, then second set overrides
		wr(OFS_FUNC, 32'h0000_0006, 4'hF, 2'h0);
		cmd_end();
		wait_gs(GS_THIRD, 10);
		repeat (4) @(posedge aclk);
		chk("obs", 32'h0000_0000, 32'(ctl_out_reg.obs_active));
		srv.second_cond <= 1'b1;
		wait_gs(GS_SECOND, 10);
		repeat (80) @(posedge aclk);
		chk("pos_gain", 32'h0000_012C, 32'(ctl_out_reg.pos_gain));
		chk("aux", 32'h0000_0001, 32'(ctl_out_reg.aux_second));
		srv.second_cond <= 1'b0;
		wait_gs(GS_THIRD, 10);
		srv.servo_on <= 1'b0;
		wait_gs(GS_FIRST, 5);
		srv.servo_on <= 1'b1;
		srv.mode <= MODE_VEL;
		cmd_end();
		repeat (10) @(posedge aclk);
		wait_gs(GS_FIRST, 0);
		srv.mode <= MODE_POS;
		wr(OFS_HOLD, 32'h0000_0000, 4'hF, 2'h0);
		wr(OFS_RATIO, 32'h0000_0064, 4'hF, 2'h0);
		cmd_end();
		repeat (10) @(posedge aclk);
		wait_gs(GS_FIRST, 0);
		wrap_up();
	end
endmodule
`default_nettype wire
